// ---- adc_seq_pkg.sv ----
package adc_seq_pkg;

    // ------------------------------------------------------------
    // Register map and bus widths
    // ------------------------------------------------------------
    localparam int          ADDR_W            = 3;
    localparam int          DATA_W            = 16;
    localparam int          RES_W             = 10;
    localparam int          NUM_CHAN          = 4;
    localparam logic [2:0]  CONV_CTRL_STATUS_REG = 3'h0;
    localparam logic [2:0]  TRIG_CTRL_REG     = 3'h1;
    localparam logic [2:0]  RESULT_REG_FIRST  = 3'h4;
    localparam logic [2:0]  RESULT_REG_SECOND = 3'h5;
    localparam logic [2:0]  RESULT_REG_THIRD  = 3'h6;
    localparam logic [2:0]  RESULT_REG_FOURTH = 3'h7;

    // ------------------------------------------------------------
    // Control/status field positions and reset values
    // ------------------------------------------------------------
    localparam int          DONE_FLAG_BIT     = 7;
    localparam int          IRQ_EN_BIT        = 6;
    localparam int          GO_BIT            = 5;
    localparam int          SCAN_BIT          = 4;
    localparam int          SPEED_BIT         = 3;
    localparam int          RESV_BIT          = 2;
    localparam int          CHAN_SEL_HI_BIT   = 1;
    localparam int          CHAN_SEL_LO_BIT   = 0;
    localparam int          TRIG_SEL_HI_BIT   = 7;
    localparam int          TRIG_SEL_LO_BIT   = 6;
    localparam logic [5:0]  TRIG_CTRL_ONES    = 6'h3f;
    localparam logic [7:0]  CTRL_RESET        = 8'h00;
    localparam logic [1:0]  TRIG_SEL_RESET    = 2'h0;

    // ------------------------------------------------------------
    // Trigger source codes
    // ------------------------------------------------------------
    localparam logic [1:0]  TRIG_NONE         = 2'h0;
    localparam logic [1:0]  TRIG_TIMER_PULSE  = 2'h1;
    localparam logic [1:0]  TRIG_TIMER8       = 2'h2;
    localparam logic [1:0]  TRIG_EXT_PIN      = 2'h3;

    // ------------------------------------------------------------
    // Timing counts in states (one state is one clock)
    // ------------------------------------------------------------
    localparam logic [7:0]  TD_MIN_SLOW       = 8'h0a;
    localparam logic [7:0]  TD_MIN_FAST       = 8'h06;
    localparam logic [2:0]  TD_SPAN_SLOW      = 3'h7;
    localparam logic [2:0]  TD_SPAN_FAST      = 3'h3;
    localparam logic [7:0]  SAMPLE_SLOW       = 8'h3f;
    localparam logic [7:0]  SAMPLE_FAST       = 8'h1f;
    localparam logic [7:0]  CONV_SLOW         = 8'hba;
    localparam logic [7:0]  CONV_FAST         = 8'h5e;
    localparam logic [4:0]  STEP_SLOW         = 5'h12;
    localparam logic [4:0]  STEP_FAST         = 5'h09;
    localparam logic [7:0]  GAP_SLOW          = 8'h07;
    localparam logic [7:0]  GAP_FAST          = 8'h03;
    localparam logic [8:0]  TOTAL_MIN_SLOW    = 9'h103;
    localparam logic [8:0]  TOTAL_MAX_SLOW    = 9'h10a;
    localparam logic [8:0]  TOTAL_MIN_FAST    = 9'h083;
    localparam logic [8:0]  TOTAL_MAX_FAST    = 9'h086;
    localparam logic [8:0]  TOTAL_NEXT_SLOW   = 9'h100;
    localparam logic [8:0]  TOTAL_NEXT_FAST   = 9'h080;
    localparam logic [9:0]  SAR_FIRST_TRIAL   = 10'h200;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_DELAY,
        ST_SAMPLE,
        ST_CONVERT
    } conv_state_t;

endpackage

// ---- adc_sequencer_control.sv ----
// The placing of the registers and strobed register access are this design's own decisions.
`timescale 1ns/10ps

module adc_sequencer_control
    import adc_seq_pkg::*;
(
    input  wire logic              clk_i,
    input  wire logic              rst_n_i,
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic [DATA_W-1:0] wdata_i,
    input  wire logic              wr_i,
    input  wire logic              rd_i,
    output logic      [DATA_W-1:0] rdata_o,
    input  wire logic              cmp_i,
    output logic                   sample_o,
    output logic      [1:0]        chan_o,
    output logic      [RES_W-1:0]  dac_code_o,
    input  wire logic              timer_pulse_trig_i,
    input  wire logic              timer8_trig_i,
    input  wire logic              ext_trig_n_pin_i,
    input  wire logic              xfer_rd_i,
    input  wire logic              xfer_irq_pass_i,
    input  wire logic              xfer_cnt_zero_i,
    output logic                   conv_done_irq_o
);

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic              rst_meta;
    logic              rst_n;

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end
        else
        begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    conv_state_t       state;
    conv_state_t       next_state;
    logic              done_flag;
    logic              next_done_flag;
    logic              done_irq_enable;
    logic              go;
    logic              scan;
    logic              speed;
    logic              resv;
    logic [1:0]        chan_sel;
    logic [1:0]        trig_source_sel;
    logic              flag_seen;
    logic              ext_prev;
    logic [2:0]        free_cnt;
    logic [7:0]        cnt;
    logic [4:0]        step_cnt;
    logic [RES_W-1:0]  bit_mask;
    logic [RES_W-1:0]  sar;
    logic [1:0]        cur_chan;
    logic [RES_W-1:0]  result [NUM_CHAN];
    logic              first_conv;
    logic              ctrl_wr;
    logic              ctrl_rd;
    logic              trig_fire;
    logic              conv_end;
    logic              last_chan;
    logic              go_set;
    logic              go_clr;
    logic              flag_clr;
    logic [7:0]        samp_len;
    logic [7:0]        conv_len;
    logic [4:0]        step_len;
    logic [7:0]        start_delay;
    logic [7:0]        gap_len;

    // ------------------------------------------------------------
    // Decode and speed-dependent counts
    // ------------------------------------------------------------
    assign ctrl_wr     = wr_i && (addr_i == CONV_CTRL_STATUS_REG);
    assign ctrl_rd     = rd_i && (addr_i == CONV_CTRL_STATUS_REG);
    assign samp_len    = speed ? SAMPLE_FAST : SAMPLE_SLOW;
    assign conv_len    = speed ? CONV_FAST : CONV_SLOW;
    assign step_len    = speed ? STEP_FAST : STEP_SLOW;
    assign gap_len     = speed ? GAP_FAST : GAP_SLOW;
    assign start_delay = speed ? TD_MIN_FAST + {6'h00, free_cnt[1:0] & TD_SPAN_FAST[1:0]}
                               : TD_MIN_SLOW + {5'h00, free_cnt & TD_SPAN_SLOW};
    assign conv_end    = (state == ST_CONVERT) && (cnt == conv_len - 8'h01);
    assign last_chan   = !scan || (cur_chan == chan_sel);

    // ------------------------------------------------------------
    // Trigger selection
    // ------------------------------------------------------------
    always_comb
    begin
        unique case (trig_source_sel)
            TRIG_NONE:        trig_fire = 1'b0;
            TRIG_TIMER_PULSE: trig_fire = timer_pulse_trig_i;
            TRIG_TIMER8:      trig_fire = timer8_trig_i;
            TRIG_EXT_PIN:     trig_fire = ext_prev && !ext_trig_n_pin_i;
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ext_prev <= 1'b1;
            free_cnt <= 3'h0;
        end
        else
        begin
            ext_prev <= ext_trig_n_pin_i;
            free_cnt <= free_cnt + 3'h1;
        end
    end

    // ------------------------------------------------------------
    // Control/status register
    // ------------------------------------------------------------
    assign go_set   = (ctrl_wr && wdata_i[GO_BIT]) || trig_fire;
    assign go_clr   = (ctrl_wr && !wdata_i[GO_BIT]) || (conv_end && !scan);
    assign flag_clr = (ctrl_wr && !wdata_i[DONE_FLAG_BIT] && flag_seen)
                   || (rd_i && addr_i[2] && xfer_rd_i && !xfer_irq_pass_i && !xfer_cnt_zero_i);

    always_comb
    begin
        next_done_flag = done_flag;
        if (conv_end && last_chan)
            next_done_flag = 1'b1;
        else if (flag_clr)
            next_done_flag = 1'b0;
    end

    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            done_flag       <= CTRL_RESET[DONE_FLAG_BIT];
            done_irq_enable <= CTRL_RESET[IRQ_EN_BIT];
            scan            <= CTRL_RESET[SCAN_BIT];
            speed           <= CTRL_RESET[SPEED_BIT];
            resv            <= CTRL_RESET[RESV_BIT];
            chan_sel        <= CTRL_RESET[CHAN_SEL_HI_BIT:CHAN_SEL_LO_BIT];
            trig_source_sel <= TRIG_SEL_RESET;
            conv_done_irq_o <= 1'b0;
        end
        else
        begin
            done_flag <= next_done_flag;
            if (ctrl_wr)
            begin
                done_irq_enable <= wdata_i[IRQ_EN_BIT];
                scan            <= wdata_i[SCAN_BIT];
                speed           <= wdata_i[SPEED_BIT];
                resv            <= wdata_i[RESV_BIT];
                chan_sel        <= wdata_i[CHAN_SEL_HI_BIT:CHAN_SEL_LO_BIT];
            end
            if (wr_i && (addr_i == TRIG_CTRL_REG))
                trig_source_sel <= wdata_i[TRIG_SEL_HI_BIT:TRIG_SEL_LO_BIT];
            conv_done_irq_o <= next_done_flag && (ctrl_wr ? wdata_i[IRQ_EN_BIT] : done_irq_enable);
        end
    end

    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
            go <= CTRL_RESET[GO_BIT];
        else if (go_set)
            go <= 1'b1;
        else if (go_clr)
            go <= 1'b0;
    end

    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
            flag_seen <= 1'b0;
        else if (ctrl_wr)
            flag_seen <= 1'b0;
        else if (ctrl_rd && done_flag)
            flag_seen <= 1'b1;
    end

    // ------------------------------------------------------------
    // Sequencer state machine
    // ------------------------------------------------------------
    always_comb
    begin
        next_state = state;
        unique case (state)
            ST_IDLE:
                if (go)
                    next_state = ST_DELAY;
            ST_DELAY:
                if (!go)
                    next_state = ST_IDLE;
                else if (cnt == 8'h00)
                    next_state = ST_SAMPLE;
            ST_SAMPLE:
                if (!go)
                    next_state = ST_IDLE;
                else if (cnt == 8'h00)
                    next_state = ST_CONVERT;
            ST_CONVERT:
                if (!go)
                    next_state = ST_IDLE;
                else if (conv_end)
                    next_state = scan ? ST_DELAY : ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state    <= ST_IDLE;
            sample_o <= 1'b0;
        end
        else
        begin
            state    <= next_state;
            sample_o <= (next_state == ST_SAMPLE);
        end
    end

    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt        <= 8'h00;
            cur_chan   <= 2'h0;
            first_conv <= 1'b0;
        end
        else if (state == ST_IDLE)
        begin
            cnt        <= start_delay - 8'h02;
            cur_chan   <= scan ? 2'h0 : chan_sel;
            first_conv <= 1'b1;
        end
        else if (state == ST_DELAY)
            cnt <= (cnt == 8'h00) ? samp_len - 8'h01 : cnt - 8'h01;
        else if (state == ST_SAMPLE)
            cnt <= (cnt == 8'h00) ? 8'h00 : cnt - 8'h01;
        else if (conv_end)
        begin
            cnt        <= gap_len - 8'h01;
            cur_chan   <= last_chan ? 2'h0 : cur_chan + 2'h1;
            first_conv <= 1'b0;
        end
        else
            cnt <= cnt + 8'h01;
    end

    // ------------------------------------------------------------
    // Successive approximation
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sar      <= 10'h000;
            bit_mask <= 10'h000;
            step_cnt <= 5'h00;
        end
        else if (state != ST_CONVERT)
        begin
            sar      <= SAR_FIRST_TRIAL;
            bit_mask <= SAR_FIRST_TRIAL;
            step_cnt <= 5'h00;
        end
        else if (step_cnt == step_len - 5'h01)
        begin
            step_cnt <= 5'h00;
            if (bit_mask != 10'h000)
            begin
                sar      <= (cmp_i ? sar : (sar & ~bit_mask)) | (bit_mask >> 1);
                bit_mask <= bit_mask >> 1;
            end
        end
        else
            step_cnt <= step_cnt + 5'h01;
    end

    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            chan_o     <= 2'h0;
            dac_code_o <= 10'h000;
        end
        else
        begin
            chan_o     <= cur_chan;
            dac_code_o <= sar;
        end
    end

    // ------------------------------------------------------------
    // Result registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < NUM_CHAN; i++)
                result[i] <= 10'h000;
        end
        else if (conv_end)
            result[cur_chan] <= sar;
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
            rdata_o <= 16'h0000;
        else if (!rd_i)
            rdata_o <= 16'h0000;
        else
        begin
            unique case (addr_i)
                CONV_CTRL_STATUS_REG:
                    rdata_o <= {8'h00, done_flag, done_irq_enable, go, scan, speed, resv, chan_sel};
                TRIG_CTRL_REG:
                    rdata_o <= {8'h00, trig_source_sel, TRIG_CTRL_ONES};
                RESULT_REG_FIRST:
                    rdata_o <= {6'h00, result[0]};
                RESULT_REG_SECOND:
                    rdata_o <= {6'h00, result[1]};
                RESULT_REG_THIRD:
                    rdata_o <= {6'h00, result[2]};
                RESULT_REG_FOURTH:
                    rdata_o <= {6'h00, result[3]};
                default:
                    rdata_o <= 16'h0000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n);

    logic [8:0]        tot_cnt;
    logic [7:0]        samp_seen;

    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tot_cnt   <= 9'h000;
            samp_seen <= 8'h00;
        end
        else
        begin
            tot_cnt   <= (state == ST_IDLE) ? 9'h002 : (conv_end ? 9'h001 : tot_cnt + 9'h001);
            samp_seen <= (state == ST_SAMPLE) ? samp_seen + 8'h01 : 8'h00;
        end
    end

    sequence seq_single_end;
        conv_end && !scan && go && !go_set;
    endsequence

    sequence seq_idle_after_end;
        ##1 (state == ST_IDLE) && !go && done_flag;
    endsequence

    a_single_end_idle: assert property (seq_single_end |-> seq_idle_after_end)
        else $error("single conversion end did not idle with flag set");

    a_go_held_busy: assert property ((state != ST_IDLE) && go && !go_clr |=> go)
        else $error("go bit low while converting");

    a_irq_tracks_flag: assert property (conv_done_irq_o == (done_flag && done_irq_enable))
        else $error("interrupt request does not follow flag and enable");

    a_ext_trig_go: assert property ((trig_source_sel == TRIG_EXT_PIN) && ext_prev && !ext_trig_n_pin_i |=> go)
        else $error("pin falling edge did not set go");

    a_flag_clear_cause: assert property ($fell(done_flag) |-> $past(flag_clr))
        else $error("done flag cleared without a clearing cause");

    a_scan_start_chan0: assert property ((state == ST_IDLE) && go && scan |=> cur_chan == 2'h0)
        else $error("scan did not begin at channel 0");

    a_sample_length: assert property ((state == ST_SAMPLE) && (next_state == ST_CONVERT)
                                      |-> samp_seen == samp_len - 8'h01)
        else $error("sampling interval has wrong length");

    a_first_conv_time: assert property (conv_end && first_conv |->
        (speed ? (tot_cnt >= TOTAL_MIN_FAST && tot_cnt <= TOTAL_MAX_FAST)
               : (tot_cnt >= TOTAL_MIN_SLOW && tot_cnt <= TOTAL_MAX_SLOW)))
        else $error("first conversion time out of range");

    a_next_conv_time: assert property (conv_end && !first_conv |->
        tot_cnt == (speed ? TOTAL_NEXT_FAST : TOTAL_NEXT_SLOW))
        else $error("later scan conversion time wrong");

    a_sar_first_trial: assert property ($rose(state == ST_CONVERT) |-> sar == SAR_FIRST_TRIAL)
        else $error("approximation did not start at mid scale");

    a_scan_wraps: assert property (conv_end && scan && last_chan && go |=> done_flag && cur_chan == 2'h0)
        else $error("scan did not set flag and wrap to channel 0");

endmodule

// ---- adc_analog_model.sv ----
`timescale 1ns/10ps
module adc_analog_model
    import adc_seq_pkg::*;
#(
    parameter logic [RES_W-1:0] LEVELS [NUM_CHAN] = '{10'h155, 10'h2aa, 10'h0f3, 10'h3ff}
)
(
    input  wire logic [1:0]       chan_i,
    input  wire logic [RES_W-1:0] code_i,
    output logic                  cmp_o
);
    // ----------------------------------------
    // Comparator against the trial code
    // ----------------------------------------
    assign cmp_o = (LEVELS[chan_i] >= code_i);
endmodule

// ---- tb_adc_sequencer_control.sv ----
`timescale 1ns/10ps
module tb_adc_sequencer_control;
    import adc_seq_pkg::*;
    localparam logic [RES_W-1:0] LV [NUM_CHAN] = '{10'h155, 10'h2aa, 10'h0f3, 10'h3ff};
    logic              clk_i = 0;
    logic              rst_n_i = 0;
    logic [ADDR_W-1:0] addr_i = '0;
    logic [DATA_W-1:0] wdata_i = '0;
    logic              wr_i = 0;
    logic              rd_i = 0;
    logic              ext_trig_n_pin_i = 1;
    logic              timer_pulse_trig_i = 0;
    logic              timer8_trig_i = 0;
    logic              xfer_rd_i = 0;
    logic              xfer_irq_pass_i = 0;
    logic              xfer_cnt_zero_i = 0;
    logic [DATA_W-1:0] rdata_o;
    logic              cmp_i;
    logic              sample_o;
    logic [1:0]        chan_o;
    logic [RES_W-1:0]  dac_code_o;
    logic              conv_done_irq_o;
    int                failures = 0;
    int                n_checks = 0;
    int                t0;
    int                cyc;
    int                n_samp = 0;

    adc_sequencer_control dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .cmp_i(cmp_i), .sample_o(sample_o), .chan_o(chan_o),
        .dac_code_o(dac_code_o), .timer_pulse_trig_i(timer_pulse_trig_i), .timer8_trig_i(timer8_trig_i),
        .ext_trig_n_pin_i(ext_trig_n_pin_i), .xfer_rd_i(xfer_rd_i), .xfer_irq_pass_i(xfer_irq_pass_i),
        .xfer_cnt_zero_i(xfer_cnt_zero_i), .conv_done_irq_o(conv_done_irq_o));
    adc_analog_model #(.LEVELS(LV)) model (.chan_i(chan_o), .code_i(dac_code_o), .cmp_o(cmp_i));

    initial
    begin
        forever #5 clk_i = ~clk_i;
    end

    // Sampling cycle counter
    always @(posedge clk_i)
        if (sample_o === 1'b1) n_samp++;

    // ----------------------------------------
    // Bus and check tasks
    // ----------------------------------------
    task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge clk_i);
        wr_i    <= 1'b0;
        t0 = $time;
    endtask

    task automatic chk_rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
        @(posedge clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clk_i);
        rd_i   <= 1'b0;
        #1;
        chk(rdata_o, e);
    endtask

    task automatic chk_xrd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e, input logic [1:0] blk);
        @(posedge clk_i);
        addr_i    <= a;
        rd_i      <= 1'b1;
        xfer_rd_i <= 1'b1;
        {xfer_irq_pass_i, xfer_cnt_zero_i} <= blk;
        @(posedge clk_i);
        rd_i      <= 1'b0;
        xfer_rd_i <= 1'b0;
        {xfer_irq_pass_i, xfer_cnt_zero_i} <= 2'h0;
        #1;
        chk(rdata_o, e);
    endtask

    task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] e);
        n_checks++;
        if (got !== e)
        begin
            $display("[ERR] %0t got %h expected %h", $time, got, e);
            failures++;
        end
    endtask

    task automatic wait_irq(input int lo, input int hi);
        for (int i = 0; i < 1000 && conv_done_irq_o !== 1'b1; i++) @(posedge clk_i) #1;
        cyc = ($time - t0 - 1) / 10;
        chk({15'h0, (cyc >= lo && cyc <= hi)}, 16'h0001);
    endtask

    task automatic close_out;
        if (failures == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset;
        chk_rd(3'h0, 16'h0000);
        chk_rd(3'h1, 16'h003f);
        chk_rd(3'h2, 16'h0000);
    endtask

    task automatic t_single;
        wr_reg(3'h0, 16'h0069);
        n_samp = 0;
        #1 chk(16'(conv_done_irq_o), 16'h0000);
        wait_irq(131, 134);
        chk(16'(n_samp), 16'h001f);
        chk(16'(chan_o), 16'h0001);
        chk(16'(dac_code_o), 16'(LV[1]));
        chk_rd(3'h0, 16'h00c9);
        chk_rd(3'h5, 16'(LV[1]));
    endtask

    task automatic t_clear;
        wr_reg(3'h0, 16'h00c9);
        wr_reg(3'h0, 16'h0049);
        #1 chk(16'(conv_done_irq_o), 16'h0001);
        chk_rd(3'h0, 16'h00c9);
        wr_reg(3'h0, 16'h0049);
        @(posedge clk_i) #1 chk(16'(conv_done_irq_o), 16'h0000);
        chk_rd(3'h0, 16'h0049);
    endtask

    task automatic t_slow;
        wr_reg(3'h0, 16'h0043);
        @(posedge clk_i);
        timer_pulse_trig_i <= 1'b1;
        timer8_trig_i      <= 1'b1;
        @(posedge clk_i);
        timer_pulse_trig_i <= 1'b0;
        timer8_trig_i      <= 1'b0;
        chk_rd(3'h0, 16'h0043);
        wr_reg(3'h1, 16'h0080);
        @(posedge clk_i);
        timer8_trig_i <= 1'b1;
        @(posedge clk_i);
        timer8_trig_i <= 1'b0;
        t0 = $time;
        n_samp = 0;
        wait_irq(259, 266);
        chk(16'(n_samp), 16'h003f);
        chk(16'(chan_o), 16'h0003);
        chk(16'(dac_code_o), 16'(LV[3]));
        chk_xrd(3'h7, 16'(LV[3]), 2'h2);
        chk_xrd(3'h7, 16'(LV[3]), 2'h1);
        chk(16'(conv_done_irq_o), 16'h0001);
        chk_xrd(3'h7, 16'(LV[3]), 2'h0);
        chk(16'(conv_done_irq_o), 16'h0000);
        chk_rd(3'h0, 16'h0043);
    endtask

    task automatic t_scan;
        wr_reg(3'h1, 16'h00c0);
        wr_reg(3'h0, 16'h005a);
        @(posedge clk_i);
        ext_trig_n_pin_i <= 1'b0;
        @(posedge clk_i);
        ext_trig_n_pin_i <= 1'b1;
        t0 = $time;
        n_samp = 0;
        wait_irq(387, 390);
        chk(16'(n_samp), 16'h005d);
        chk_rd(3'h4, 16'(LV[0]));
        chk_rd(3'h5, 16'(LV[1]));
        chk_rd(3'h6, 16'(LV[2]));
        chk_rd(3'h0, 16'h00fa);
        wr_reg(3'h0, 16'h005a);
        chk_rd(3'h0, 16'h005a);
    endtask

    initial
    begin
        #200000;
        failures++;
        close_out();
    end

    initial
    begin
        repeat (2) @(posedge clk_i);
        rst_n_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        t_reset();
        t_single();
        t_clear();
        t_slow();
        t_scan();
        close_out();
    end
endmodule
